// [logic/iocn_pkg.sv]
/*
 * Constants for the I/O cell and clock net block: register offsets,
 * field positions, reset values, selector encodings and rate figures.
 * Assumes a 32-bit classic Wishbone slave with byte addressing.
 */
package iocn_pkg;

	// ************************************************************
	// Sizes
	// ************************************************************
	localparam int IOCN_CELLS = 8;
	localparam int IOCN_SEQ = 8;
	localparam int IOCN_AW = 8;
	localparam int IOCN_DW = 32;

	// ************************************************************
	// Register byte offsets
	// ************************************************************
	localparam logic [IOCN_AW-1:0] IOCN_BYPASS_OFS = 8'h00;
	localparam logic [IOCN_AW-1:0] IOCN_CELLCFG_OFS = 8'h04;
	localparam logic [IOCN_AW-1:0] IOCN_SEQCFG_OFS = 8'h08;
	localparam logic [IOCN_AW-1:0] IOCN_ROUTE_OFS = 8'h0C;
	localparam logic [IOCN_AW-1:0] IOCN_STATUS_OFS = 8'h10;

	// ************************************************************
	// Field positions (low bit of each field)
	// ************************************************************
	localparam int IOCN_OUT_BYP_LSB = 0;
	localparam int IOCN_IN_BYP_LSB = 8;
	localparam int IOCN_PRESET_LSB = 0;
	localparam int IOCN_FB_SEL_LSB = 8;
	localparam int IOCN_LATCH_LSB = 0;
	localparam int IOCN_CKSEL_LSB = 8;
	localparam int IOCN_NET0_LSB = 0;
	localparam int IOCN_NET1_LSB = 2;
	localparam int IOCN_ST_OUT_LSB = 0;
	localparam int IOCN_ST_IN_LSB = 8;
	localparam int IOCN_ST_SEQ_LSB = 16;

	// ************************************************************
	// Reset values
	// ************************************************************
	localparam logic [IOCN_DW-1:0] IOCN_BYPASS_RST = 32'h0000_0000;
	localparam logic [IOCN_DW-1:0] IOCN_CELLCFG_RST = 32'h0000_0000;
	localparam logic [IOCN_DW-1:0] IOCN_SEQCFG_RST = 32'h0000_0000;
	localparam logic [IOCN_DW-1:0] IOCN_ROUTE_RST = 32'h0000_0000;
	localparam logic [IOCN_DW-1:0] IOCN_UNMAPPED_VAL = 32'h0000_0000;

	// ************************************************************
	// Selector encodings
	// ************************************************************
	typedef enum logic [1:0] {
		IOCN_SRC_PAD_A = 2'h0,
		IOCN_SRC_PAD_B = 2'h1,
		IOCN_SRC_INT_A = 2'h2,
		IOCN_SRC_INT_B = 2'h3
	} iocn_src_t;

	typedef enum logic [1:0] {
		IOCN_CK_NET0 = 2'h0,
		IOCN_CK_NET1 = 2'h1,
		IOCN_CK_ARRAY = 2'h2
	} iocn_cksel_t;

	// ************************************************************
	// Rate limits of the clock nets
	// ************************************************************
	localparam int IOCN_DEDICATED_MAX_MHZ = 200;
	localparam int IOCN_ROUTED_MAX_MHZ = 150;

endpackage

// [logic/iocn_top.sv]
/*
 * I/O cells with inbound and outbound registers, pad driver control,
 * sequential array cells and two routed clock nets with source select,
 * configured over a classic Wishbone slave.
 * Assumes one 200 MHz clock; every clock net is a one-cycle enable
 * pulse or level sampled on clk_i, and all inputs are synchronous.
 */
// Implementation choices: the Wishbone slave port and the address map.
// What this block does
// [R1] Each I/O cell has inbound and outbound registers on the I/O clock net.
// [R2] Either register can be bypassed to give a combinational path.
// [R3] Each register has its own load enable from the array.
// [R4] With load enable low at the clock, a register keeps its value.
// [R5] Preset/clear net initialises cell registers; per cell preset or clear.
// [R6] Feedback carries pad input or outbound register value into array.
// [R7] Pad driver is tristate; drive, receive, outbound and inbound signals.
// [R8] Global drive, receive enable and edge rate act only in programming mode.
// [R9] Special pins behave as normal I/O while programming mode is inactive.
// [R10] Sequential cell: combinational function plus clearable latch or flip-flop.
// [R11] Sequential cell clock picks routed net zero, one or array clock.
// [R12] Dedicated array and I/O clock nets feed registers without selection.
// [R13] Dedicated nets run up to 200 MHz, routed nets up to 150 MHz.
// [R14] Each routed net selects pad A, pad B, internal A or internal B.
// [R15] Routed nets may also carry resets, output enables or data enables.
`timescale 1ns/1ps

module iocn_top
	import iocn_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [IOCN_AW-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [IOCN_DW-1:0] wb_dat_i,
	output logic [IOCN_DW-1:0] wb_dat_o,
	output logic wb_ack_o,
	// Dedicated clock nets, as enables on clk_i
	input wire logic io_register_clock_net_i,
	input wire logic array_clock_net_i,
	input wire logic io_preset_clear_net_i,
	// Array side of the I/O cells
	input wire logic [IOCN_CELLS-1:0] core_out_data_i,
	input wire logic [IOCN_CELLS-1:0] outbound_register_load_enable_i,
	input wire logic [IOCN_CELLS-1:0] inbound_register_load_enable_i,
	input wire logic [IOCN_CELLS-1:0] drive_enable_i,
	input wire logic [IOCN_CELLS-1:0] pad_receive_enable_i,
	output logic [IOCN_CELLS-1:0] cell_feedback_o,
	// Programming and test controls
	input wire logic program_mode_i,
	input wire logic global_drive_enable_i,
	input wire logic global_receive_enable_i,
	input wire logic [IOCN_CELLS-1:0] edge_rate_select_i,
	// Pads
	input wire logic [IOCN_CELLS-1:0] pad_i,
	output logic [IOCN_CELLS-1:0] pad_o,
	output logic [IOCN_CELLS-1:0] pad_oe_o,
	output logic [IOCN_CELLS-1:0] pad_slow_edge_o,
	// Routed clock sources and nets
	input wire logic routed_clock_pad_a_i,
	input wire logic routed_clock_pad_b_i,
	input wire logic internal_clock_source_a_i,
	input wire logic internal_clock_source_b_i,
	output logic routed_clock_net_zero_o,
	output logic routed_clock_net_one_o,
	// Sequential array cells
	input wire logic [IOCN_SEQ-1:0] seq_in_a_i,
	input wire logic [IOCN_SEQ-1:0] seq_in_b_i,
	input wire logic [IOCN_SEQ-1:0] seq_in_sel_i,
	input wire logic [IOCN_SEQ-1:0] sequential_clear_input_i,
	output logic [IOCN_SEQ-1:0] seq_q_o
);

	// ************************************************************
	// Helpers
	// ************************************************************

	// Byte-lane merge for Wishbone writes
	function automatic logic [IOCN_DW-1:0] iocn_merge(input logic [IOCN_DW-1:0] old_v,
		input logic [IOCN_DW-1:0] new_v, input logic [3:0] sel);
		logic [IOCN_DW-1:0] res;
		res = old_v;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				res[b*8 +: 8] = new_v[b*8 +: 8];
			end
		end
		return res;
	endfunction

	// Four-way routed net source selector
	function automatic logic iocn_route(input logic [1:0] src, input logic pa,
		input logic pb, input logic ia, input logic ib);
		logic v;
		case (iocn_src_t'(src))
			IOCN_SRC_PAD_A: v = pa;
			IOCN_SRC_PAD_B: v = pb;
			IOCN_SRC_INT_A: v = ia;
			IOCN_SRC_INT_B: v = ib;
			default: v = 1'b0;
		endcase
		return v;
	endfunction

	// ************************************************************
	// Configuration registers
	// ************************************************************
	logic [IOCN_DW-1:0] bypass_r;
	logic [IOCN_DW-1:0] cellcfg_r;
	logic [IOCN_DW-1:0] seqcfg_r;
	logic [IOCN_DW-1:0] route_r;
	logic wb_req;
	logic wb_wr;
	logic [IOCN_DW-1:0] rd_nxt;

	logic [IOCN_CELLS-1:0] out_q_r;
	logic [IOCN_CELLS-1:0] in_q_r;
	logic [IOCN_SEQ-1:0] seq_q_r;

	// A request is taken once; ack drops the cycle after it was given
	assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wb_wr = wb_req & wb_we_i;

	// Single-cycle answer, unmapped offsets ack with zero data
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= wb_req;
		end
	end

	// Register writes honour byte selects
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			bypass_r <= IOCN_BYPASS_RST;
			cellcfg_r <= IOCN_CELLCFG_RST;
			seqcfg_r <= IOCN_SEQCFG_RST;
			route_r <= IOCN_ROUTE_RST;
		end else if (wb_wr) begin
			case (wb_adr_i)
				IOCN_BYPASS_OFS: bypass_r <= iocn_merge(bypass_r, wb_dat_i, wb_sel_i);
				IOCN_CELLCFG_OFS: cellcfg_r <= iocn_merge(cellcfg_r, wb_dat_i, wb_sel_i);
				IOCN_SEQCFG_OFS: seqcfg_r <= iocn_merge(seqcfg_r, wb_dat_i, wb_sel_i);
				IOCN_ROUTE_OFS: route_r <= iocn_merge(route_r, wb_dat_i, wb_sel_i);
				default: ;
			endcase
		end
	end

	// Read mux; status shows live cell and sequential state
	always_comb begin
		rd_nxt = IOCN_UNMAPPED_VAL;
		case (wb_adr_i)
			IOCN_BYPASS_OFS: rd_nxt = bypass_r;
			IOCN_CELLCFG_OFS: rd_nxt = cellcfg_r;
			IOCN_SEQCFG_OFS: rd_nxt = seqcfg_r;
			IOCN_ROUTE_OFS: rd_nxt = route_r;
			IOCN_STATUS_OFS: begin
				rd_nxt[IOCN_ST_OUT_LSB +: IOCN_CELLS] = out_q_r;
				rd_nxt[IOCN_ST_IN_LSB +: IOCN_CELLS] = in_q_r;
				rd_nxt[IOCN_ST_SEQ_LSB +: IOCN_SEQ] = seq_q_r;
			end
			default: rd_nxt = IOCN_UNMAPPED_VAL;
		endcase
	end

	// Read data held in flops, valid with ack
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= IOCN_UNMAPPED_VAL;
		end else if (wb_req & ~wb_we_i) begin
			wb_dat_o <= rd_nxt;
		end
	end

	// ************************************************************
	// Field views
	// ************************************************************
	logic [IOCN_CELLS-1:0] out_bypass;
	logic [IOCN_CELLS-1:0] in_bypass;
	logic [IOCN_CELLS-1:0] preset_sel;
	logic [IOCN_CELLS-1:0] fb_sel;
	logic [IOCN_SEQ-1:0] latch_mode;

	assign out_bypass = bypass_r[IOCN_OUT_BYP_LSB +: IOCN_CELLS];
	assign in_bypass = bypass_r[IOCN_IN_BYP_LSB +: IOCN_CELLS];
	assign preset_sel = cellcfg_r[IOCN_PRESET_LSB +: IOCN_CELLS];
	assign fb_sel = cellcfg_r[IOCN_FB_SEL_LSB +: IOCN_CELLS];
	assign latch_mode = seqcfg_r[IOCN_LATCH_LSB +: IOCN_SEQ];

	// ************************************************************
	// Pad drivers
	// ************************************************************
	logic [IOCN_CELLS-1:0] core_to_pad_value;
	logic [IOCN_CELLS-1:0] pad_to_core_value;
	logic [IOCN_CELLS-1:0] rx_en;

	// Global controls only take over while programming mode is active
	always_comb begin
		if (program_mode_i) begin
			pad_oe_o = {IOCN_CELLS{global_drive_enable_i}}; // [R8]
			rx_en = {IOCN_CELLS{global_receive_enable_i}}; // [R8]
			pad_slow_edge_o = edge_rate_select_i; // [R8]
		end else begin
			pad_oe_o = drive_enable_i; // [R9]
			rx_en = pad_receive_enable_i; // [R9]
			pad_slow_edge_o = '0;
		end
	end

	// Tristate driver: value and enable kept apart for the bench wire
	assign pad_o = core_to_pad_value; // [R7]
	assign pad_to_core_value = pad_i & rx_en; // [R7]

	// ************************************************************
	// I/O cell registers
	// ************************************************************

	// Outbound register on the I/O clock net; preset/clear net wins
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			out_q_r <= '0;
		end else begin
			for (int i = 0; i < IOCN_CELLS; i++) begin
				if (io_preset_clear_net_i) begin
					out_q_r[i] <= preset_sel[i]; // [R5]
				end else if (io_register_clock_net_i & outbound_register_load_enable_i[i]) begin
					out_q_r[i] <= core_out_data_i[i]; // [R1] [R3] [R12]
				end
			end
		end
	end

	// Inbound register, same net; no load enable means hold
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			in_q_r <= '0;
		end else begin
			for (int i = 0; i < IOCN_CELLS; i++) begin
				if (io_preset_clear_net_i) begin
					in_q_r[i] <= preset_sel[i]; // [R5]
				end else if (io_register_clock_net_i & inbound_register_load_enable_i[i]) begin
					in_q_r[i] <= pad_to_core_value[i]; // [R1] [R3] [R12]
				end
			end
		end
	end // [R4]

	// Bypass gives a combinational path, set cell by cell
	always_comb begin
		for (int i = 0; i < IOCN_CELLS; i++) begin
			core_to_pad_value[i] = out_bypass[i] ? core_out_data_i[i] : out_q_r[i]; // [R2]
			cell_feedback_o[i] = fb_sel[i] ? out_q_r[i] // [R6]
				: (in_bypass[i] ? pad_to_core_value[i] : in_q_r[i]); // [R2]
		end
	end

	// ************************************************************
	// Routed clock nets
	// ************************************************************

	// Both nets identical; also fit for resets and enables of high fanout
	assign routed_clock_net_zero_o = iocn_route(route_r[IOCN_NET0_LSB +: 2], // [R14] [R15]
		routed_clock_pad_a_i, routed_clock_pad_b_i,
		internal_clock_source_a_i, internal_clock_source_b_i);
	assign routed_clock_net_one_o = iocn_route(route_r[IOCN_NET1_LSB +: 2], // [R14] [R15]
		routed_clock_pad_a_i, routed_clock_pad_b_i,
		internal_clock_source_a_i, internal_clock_source_b_i);

	// Rates are bounded by clk_i: dedicated nets may pulse every cycle,
	// routed sources must not exceed 150 of every 200 cycles on average
	localparam int IOCN_ROUTED_PCT = (IOCN_ROUTED_MAX_MHZ * 100) / IOCN_DEDICATED_MAX_MHZ; // [R13]

	// ************************************************************
	// Sequential array cells
	// ************************************************************
	logic [IOCN_SEQ-1:0] seq_ck;
	logic [IOCN_SEQ-1:0] seq_ck_prev_r;
	logic [IOCN_SEQ-1:0] seq_d;

	// Per-cell clock mux; the unused code falls back to the array clock
	always_comb begin
		for (int i = 0; i < IOCN_SEQ; i++) begin
			case (iocn_cksel_t'(seqcfg_r[IOCN_CKSEL_LSB + 2*i +: 2]))
				IOCN_CK_NET0: seq_ck[i] = routed_clock_net_zero_o; // [R11]
				IOCN_CK_NET1: seq_ck[i] = routed_clock_net_one_o; // [R11]
				IOCN_CK_ARRAY: seq_ck[i] = array_clock_net_i; // [R11] [R12]
				default: seq_ck[i] = array_clock_net_i;
			endcase
			seq_d[i] = seq_in_sel_i[i] ? seq_in_b_i[i] : seq_in_a_i[i]; // [R10]
		end
	end

	// Previous clock level, for edge detection in flip-flop mode
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			seq_ck_prev_r <= '0;
		end else begin
			seq_ck_prev_r <= seq_ck;
		end
	end

	// Latch follows while clock high; flip-flop loads on rising level
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			seq_q_r <= '0;
		end else begin
			for (int i = 0; i < IOCN_SEQ; i++) begin
				if (sequential_clear_input_i[i]) begin
					seq_q_r[i] <= 1'b0; // [R10]
				end else if (latch_mode[i] ? seq_ck[i] : (seq_ck[i] & ~seq_ck_prev_r[i])) begin
					seq_q_r[i] <= seq_d[i]; // [R10]
				end
			end
		end
	end

	assign seq_q_o = seq_q_r;

endmodule

// [dv/iocn_top_monitor.sv]
/* Checker for iocn_top: bus timing, pad control, outbound cell registers, nets.
 * Assumes it is bound to iocn_top and sees only that module's ports. */
`timescale 1ns/1ps
module iocn_top_monitor
	import iocn_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [IOCN_AW-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [IOCN_DW-1:0] wb_dat_i,
	input wire logic wb_ack_o,
	input wire logic io_register_clock_net_i,
	input wire logic io_preset_clear_net_i,
	input wire logic [IOCN_CELLS-1:0] core_out_data_i,
	input wire logic [IOCN_CELLS-1:0] outbound_register_load_enable_i,
	input wire logic [IOCN_CELLS-1:0] drive_enable_i,
	input wire logic program_mode_i,
	input wire logic [IOCN_CELLS-1:0] edge_rate_select_i,
	input wire logic [IOCN_CELLS-1:0] pad_o,
	input wire logic [IOCN_CELLS-1:0] pad_oe_o,
	input wire logic [IOCN_CELLS-1:0] pad_slow_edge_o,
	input wire logic routed_clock_pad_a_i,
	input wire logic routed_clock_pad_b_i,
	input wire logic internal_clock_source_a_i,
	input wire logic internal_clock_source_b_i,
	input wire logic routed_clock_net_zero_o,
	input wire logic routed_clock_net_one_o
);
	// ********************
	// Bus snoop
	// ********************
	logic [7:0] obyp_r;
	logic [3:0] route_r;
	wire take = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire wr_lo = take & wb_we_i & wb_sel_i[0];
	wire wr_byp = wr_lo & (wb_adr_i == IOCN_BYPASS_OFS);
	wire [3:0] srcs = {internal_clock_source_b_i, internal_clock_source_a_i,
		routed_clock_pad_b_i, routed_clock_pad_a_i};

	// Shadow copies, so the pad checks know which cells are bypassed and the net checks which sources are routed
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			obyp_r <= 8'h00;
			route_r <= 4'h0;
		end else begin
			if (wr_byp)
				obyp_r <= wb_dat_i[7:0];
			if (wr_lo && wb_adr_i == IOCN_ROUTE_OFS)
				route_r <= wb_dat_i[3:0];
		end
	end

	// ********************
	// Assertions
	// ********************
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence bus_take;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence ack_once;
		wb_ack_o ##1 !wb_ack_o;
	endsequence

	ack_latency_a: assert property (bus_take |=> ack_once)
		else $error("ack not one cycle after request");
	ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without request");
	out_hold_a: assert property (!io_preset_clear_net_i && !wr_byp |=>
		(((pad_o ^ $past(pad_o)) & ~obyp_r & ~($past(outbound_register_load_enable_i)
		& {8{$past(io_register_clock_net_i)}})) == 8'h00))
		else $error("outbound register changed without load");
	out_load_a: assert property (io_register_clock_net_i && !io_preset_clear_net_i
		&& !wr_byp |=> (((pad_o ^ $past(core_out_data_i))
		& $past(outbound_register_load_enable_i) & ~obyp_r) == 8'h00))
		else $error("outbound register missed a load");
	out_bypass_a: assert property (obyp_r == 8'hFF |-> pad_o == core_out_data_i)
		else $error("bypassed outbound path not combinational");
	drive_normal_a: assert property (!program_mode_i |-> pad_oe_o == drive_enable_i)
		else $error("pad drive enable wrong in user mode");
	slow_user_a: assert property (!program_mode_i |-> pad_slow_edge_o == 8'h00)
		else $error("edge rate active in user mode");
	slow_prog_a: assert property (program_mode_i |-> pad_slow_edge_o == edge_rate_select_i)
		else $error("edge rate not passed in programming mode");
	net_zero_a: assert property (routed_clock_net_zero_o == srcs[route_r[1:0]])
		else $error("routed net zero source wrong");
	net_one_a: assert property (routed_clock_net_one_o == srcs[route_r[3:2]])
		else $error("routed net one source wrong");
endmodule

bind iocn_top iocn_top_monitor u_iocn_top_monitor (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
	.wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o, .io_register_clock_net_i,
	.io_preset_clear_net_i, .core_out_data_i, .outbound_register_load_enable_i,
	.drive_enable_i, .program_mode_i, .edge_rate_select_i, .pad_o, .pad_oe_o,
	.pad_slow_edge_o, .routed_clock_pad_a_i, .routed_clock_pad_b_i,
	.internal_clock_source_a_i, .internal_clock_source_b_i, .routed_clock_net_zero_o,
	.routed_clock_net_one_o);

// [dv/iocn_pads.sv]
/* Board side of the pads: resolves each tristate wire.
 * Assumes the bench never drives a pad that the block drives. */
`timescale 1ns/1ps
module iocn_pads
	import iocn_pkg::*;
(
	input wire logic clk_i,
	input wire logic [IOCN_CELLS-1:0] pad_val_i,
	input wire logic [IOCN_CELLS-1:0] pad_oe_i,
	input wire logic [IOCN_CELLS-1:0] ext_val_i,
	input wire logic [IOCN_CELLS-1:0] ext_en_i,
	output logic [IOCN_CELLS-1:0] pad_level_o
);
	logic [IOCN_CELLS-1:0] last_r = '0;

	// No pull on the wire: a released pad flips, so a held value never passes
	always_ff @(posedge clk_i)
		last_r <= pad_level_o;
	assign pad_level_o = (pad_oe_i & pad_val_i) | (~pad_oe_i & ext_en_i & ext_val_i)
		| (~pad_oe_i & ~ext_en_i & ~last_r);
endmodule

// [dv/tb_iocn_top.sv]
/* Testbench for iocn_top: random cell, net and register traffic.
 * Assumes the pad model iocn_pads and the bound checker. */
`timescale 1ns/1ps
module tb_iocn_top
	import iocn_pkg::*;
;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, io_register_clock_net_i, array_clock_net_i;
	logic [IOCN_AW-1:0] wb_adr_i;
	logic [3:0] wb_sel_i;
	logic [IOCN_DW-1:0] wb_dat_i, wb_dat_o, rd;
	logic io_preset_clear_net_i, program_mode_i, global_drive_enable_i, global_receive_enable_i;
	logic routed_clock_pad_a_i, routed_clock_pad_b_i, internal_clock_source_a_i;
	logic internal_clock_source_b_i, routed_clock_net_zero_o, routed_clock_net_one_o;
	logic [7:0] core_out_data_i, outbound_register_load_enable_i, inbound_register_load_enable_i;
	logic [7:0] drive_enable_i, pad_receive_enable_i, cell_feedback_o, edge_rate_select_i;
	logic [7:0] pad_i, pad_o, pad_oe_o, pad_slow_edge_o, seq_in_a_i, seq_in_b_i, seq_in_sel_i;
	logic [7:0] sequential_clear_input_i, seq_q_o, ext_val, ext_en, out_m, in_m, seq_m, prev_m;
	logic [7:0] pin, po, fe;
	logic [31:0] cfg [4];
	logic [31:0] msk [4] = '{32'h0000_FFFF, 32'h0000_FFFF, 32'h00FF_FFFF, 32'h0000_000F};
	logic [1:0] n;
	logic quiet;
	integer seed = 83106;
	int mismatches = 0;
	int total_checks = 0;

	iocn_top u_iocn_top (.*);
	iocn_pads u_iocn_pads (.clk_i, .pad_val_i(pad_o), .pad_oe_i(pad_oe_o), .ext_val_i(ext_val),
		.ext_en_i(ext_en), .pad_level_o(pad_i));

	initial forever #2.5 clk_i = ~clk_i;

	// ********************
	// Checks and bus
	// ********************
	task chk8(input string nm, input logic [7:0] exp, input logic [7:0] got);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task chk32(input string nm, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task wrap_up;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Classic cycle; waits for ack under a bound, read data taken at that edge
	task wb_cycle(input logic we, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		int k;
		@(posedge clk_i);
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'b11, we, a, d, s};
		k = 0;
		do begin
			@(posedge clk_i);
			k++;
		end while (wb_ack_o !== 1'b1 && k < 20);
		if (k >= 20) begin
			mismatches++;
			wrap_up;
		end
		rd = wb_dat_o;
		{wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
	endtask
	function automatic logic f_net(input logic [1:0] s);
		logic [3:0] v;
		v = {internal_clock_source_b_i, internal_clock_source_a_i, routed_clock_pad_b_i,
			routed_clock_pad_a_i};
		return v[s];
	endfunction

	// ********************
	// Cell step: model the edge, drive new values, compare
	// ********************
	task step;
		logic [31:0] r1, r2, r3;
		logic [7:0] g, de, rx;
		logic ck;
		@(posedge clk_i);
		if (io_preset_clear_net_i) begin
			out_m = cfg[1][7:0];
			in_m = cfg[1][7:0];
		end else if (io_register_clock_net_i) begin
			out_m = (outbound_register_load_enable_i & core_out_data_i)
				| (~outbound_register_load_enable_i & out_m);
			in_m = (inbound_register_load_enable_i & pin) | (~inbound_register_load_enable_i & in_m);
		end
		for (int i = 0; i < 8; i++) begin
			ck = (cfg[2][8+2*i+:2] < 2'h2) ? n[cfg[2][8+2*i]] : array_clock_net_i;
			if (sequential_clear_input_i[i])
				seq_m[i] = 1'b0;
			else if (ck && (cfg[2][i] || !prev_m[i]))
				seq_m[i] = seq_in_sel_i[i] ? seq_in_b_i[i] : seq_in_a_i[i];
			prev_m[i] = ck;
		end
		r1 = $random(seed);
		r2 = $random(seed);
		r3 = $random(seed);
		{core_out_data_i, outbound_register_load_enable_i, inbound_register_load_enable_i,
			drive_enable_i} <= r1;
		{pad_receive_enable_i, ext_val, seq_in_a_i, seq_in_b_i} <= r2;
		{seq_in_sel_i, edge_rate_select_i} <= r3[15:0];
		g = quiet ? 8'h00 : r3[31:24];
		// Enables the pads should see: the global pair only in programming mode
		de = program_mode_i ? {8{g[1]}} : r1[7:0];
		rx = program_mode_i ? {8{g[0]}} : r2[31:24];
		// Board drives every received pad left free, so a floating pad is never received
		ext_en <= ~de & rx;
		sequential_clear_input_i <= quiet ? 8'h00 : r3[23:16] & r1[15:8];
		io_preset_clear_net_i <= !quiet && (&r2[2:0]);
		{io_register_clock_net_i, array_clock_net_i, routed_clock_pad_a_i, routed_clock_pad_b_i,
			internal_clock_source_a_i, internal_clock_source_b_i, global_drive_enable_i,
			global_receive_enable_i} <= g;
		#1;
		n = {f_net(cfg[3][3:2]), f_net(cfg[3][1:0])};
		po = (cfg[0][7:0] & core_out_data_i) | (~cfg[0][7:0] & out_m);
		pin = rx & ((de & po) | (~de & ext_val));
		fe = (cfg[1][15:8] & out_m) | (~cfg[1][15:8]
			& ((cfg[0][15:8] & pin) | (~cfg[0][15:8] & in_m)));
		chk8("nets", {6'h00, n}, {6'h00, routed_clock_net_one_o, routed_clock_net_zero_o});
		chk8("seq_q", seq_m, seq_q_o);
		chk8("pad_o", po, pad_o);
		chk8("slow_edge", program_mode_i ? edge_rate_select_i : 8'h00, pad_slow_edge_o);
		chk8("pad_oe", de, pad_oe_o);
		chk8("feedback", fe, cell_feedback_o);
	endtask

	// ********************
	// Main sequence
	// ********************
	initial begin
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
		{io_register_clock_net_i, array_clock_net_i, io_preset_clear_net_i, program_mode_i} = '0;
		{global_drive_enable_i, global_receive_enable_i, routed_clock_pad_a_i} = '0;
		{routed_clock_pad_b_i, internal_clock_source_a_i, internal_clock_source_b_i} = '0;
		{core_out_data_i, outbound_register_load_enable_i, inbound_register_load_enable_i} = '0;
		{drive_enable_i, pad_receive_enable_i, edge_rate_select_i, ext_val, ext_en} = '0;
		{seq_in_a_i, seq_in_b_i, seq_in_sel_i, sequential_clear_input_i} = '0;
		{out_m, in_m, seq_m, prev_m, pin, n} = '0;
		cfg = '{4{32'h0}};
		quiet = 1'b1;
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		// Reset values, read-only status and an unmapped word
		for (int a = 0; a < 6; a++) begin
			wb_cycle(1'b0, 8'(a * 4), 32'h0, 4'hF);
			chk32("reset_value", 32'h0, rd);
		end
		for (int w = 0; w < 2; w++) begin
			wb_cycle(1'b1, 8'(IOCN_STATUS_OFS + w * 4), 32'hFFFF_FFFF, 4'hF);
			wb_cycle(1'b0, 8'(IOCN_STATUS_OFS + w * 4), 32'h0, 4'hF);
			chk32("ignored_write", 32'h0, rd);
		end
		wb_cycle(1'b1, IOCN_BYPASS_OFS, 32'hFFFF_FFFF, 4'h2);
		wb_cycle(1'b0, IOCN_BYPASS_OFS, 32'h0, 4'hF);
		chk32("lane_write", 32'h0000_FF00, rd);
		// Phase 0 sets every field; phase 4 runs in programming mode
		for (int ph = 0; ph < 5; ph++) begin
			for (int k = 0; k < 4; k++) begin
				cfg[k] = (ph == 0) ? msk[k] : $random(seed) & msk[k];
				wb_cycle(1'b1, 8'(k * 4), cfg[k], 4'hF);
				wb_cycle(1'b0, 8'(k * 4), 32'h0, 4'hF);
				chk32("config", cfg[k], rd);
			end
			program_mode_i <= (ph == 4);
			quiet = 1'b0;
			repeat (60) step;
			quiet = 1'b1;
			repeat (2) step;
			if (ph < 4) begin
				wb_cycle(1'b0, IOCN_STATUS_OFS, 32'h0, 4'hF);
				chk32("status", {8'h00, seq_m, in_m, out_m}, rd);
			end
		end
		// Reset again mid-run: registers and cell stores must all clear
		@(posedge clk_i);
		rst_i <= 1'b1;
		program_mode_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		{out_m, in_m, seq_m, prev_m} = '0;
		for (int a = 0; a < 5; a++) begin
			wb_cycle(1'b0, 8'(a * 4), 32'h0, 4'hF);
			chk32("mid_reset", 32'h0, rd);
		end
		wrap_up;
	end
endmodule
